// File: src/smbus_eeprom_access_cmd.sv
//
// Function
// - After the slave address the fields come as code, count, command, device address, address low, high, data.
// - The count byte appears only in block transactions and is skipped for byte and word ones.
// - A count gives the bytes that follow it, and a returned count includes the status byte.
// - The 16-bit EEPROM byte address is sent low byte at position four and high byte at five.
// - Position six holds the one data byte, written by the host or returned by the device.
// - Command bit 0 selects write when zero and read when one.
// - With command bit 1 set the given device address replaces the configured EEPROM address.
// - Command bit 3 is set by an unexpected NACK on the master access and clears when read.
// - Command bit 4 is set after 16 lost arbitration attempts and clears when read.
// - Command bit 5 is set by a misplaced START or STOP and clears when read.
// - The three flags behave like the matching flags of the master link status.
// - The slave drives only its acknowledges, returned bytes and clock stretches on SCL; the host drives the rest.
`timescale 1ns/1ns
`default_nettype none
module smbus_eeprom_access_cmd (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic [6:0]          slave_addr,
  input  wire logic [6:0]          cfg_eeprom_addr,
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic                     acc_req_valid,
  output eeacc_pkg::acc_req_s      acc_req,
  input  wire logic                acc_done,
  input  wire eeacc_pkg::acc_res_s acc_res,
  output logic [7:0]               cmd_status
);
  import eeacc_pkg::*;

  typedef enum logic [3:0] {
    L_IDLE, L_ADDR, L_ADDR_ACK, L_WR, L_WR_HOLD, L_WR_ACK, L_RD_LOAD, L_RD, L_RD_ACK, L_RD_WAIT
  } link_e;

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       cond_start;
  logic       cond_stop;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  // Only stages 1 and 2 are looked at; stage 0 may be metastable
  assign scl_rise   = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall   = !scl_sync_q[1] && scl_sync_q[2];
  assign cond_start = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[1] && sda_sync_q[2];
  assign cond_stop  = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[1] && !sda_sync_q[2];

  // ----------------------------------------
  // Shared state
  // ----------------------------------------
  link_e      st_q;
  link_e      st_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic       first_q;
  logic       first_d;
  logic       sda_oe_q;
  logic       sda_oe_d;
  logic       scl_oe_q;
  logic       scl_oe_d;
  logic       push;
  logic       rd_clear;
  logic       fifo_ready;
  logic       pop_valid;
  logic       pop_ready;
  link_byte_s pop_byte;
  link_byte_s push_byte;
  logic [7:0] resp_byte;

  logic [2:0] pos_q;
  logic [2:0] pos_d;
  logic [7:0] code_q;
  logic [7:0] code_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [7:0] devaddr_q;
  logic [7:0] devaddr_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       pend_q;
  logic       pend_d;
  acc_req_s   req_q;
  acc_req_s   req_d;

  // ----------------------------------------
  // Buffer between link and parser
  // ----------------------------------------
  assign push_byte = '{first: first_q, data: shift_q};

  byte_fifo #(
    .WIDTH ($bits(link_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_byte),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_byte)
  );

  // ----------------------------------------
  // Returned byte sequence
  // ----------------------------------------
  always_comb
  begin
    unique case (idx_q)
      IDX_COUNT: resp_byte = RESP_COUNT;
      IDX_CMD:   resp_byte = {2'h0, flags_q, 1'b0, ctrl_q};
      3'h2:      resp_byte = devaddr_q;
      3'h3:      resp_byte = lo_q;
      3'h4:      resp_byte = hi_q;
      IDX_LAST:  resp_byte = rdata_q;
      default:   resp_byte = IDLE_FILL;
    endcase
  end

  // ----------------------------------------
  // Slave link engine
  // ----------------------------------------
  always_comb
  begin
    st_d     = st_q;
    bit_d    = bit_q;
    shift_d  = shift_q;
    idx_d    = idx_q;
    first_d  = first_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = scl_oe_q;
    push     = 1'b0;
    rd_clear = 1'b0;
    if ((st_q == L_ADDR || st_q == L_WR) && scl_rise)
    begin
      shift_d = {shift_q[6:0], sda_sync_q[1]};
      bit_d   = bit_q + 4'h1;
    end
    if (cond_start)
    begin
      st_d     = L_ADDR;
      bit_d    = 4'h0;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end
    else if (cond_stop)
    begin
      st_d     = L_IDLE;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        L_IDLE: ;
        L_ADDR:
          if (scl_fall && bit_q == BITS_BYTE)
          begin
            if (shift_q[7:1] == slave_addr)
            begin
              st_d     = L_ADDR_ACK;
              sda_oe_d = 1'b1;
              first_d  = 1'b1;
              idx_d    = code_q[CODE_BLK_BIT] ? IDX_COUNT : IDX_CMD;
            end
            else
            begin
              st_d = L_IDLE;
            end
          end
        L_ADDR_ACK, L_WR_ACK:
          if (scl_fall)
          begin
            sda_oe_d = 1'b0;
            bit_d    = 4'h0;
            st_d     = (st_q == L_ADDR_ACK && shift_q[0]) ? L_RD_LOAD : L_WR;
          end
        L_WR:
          if (scl_fall && bit_q == BITS_BYTE)
          begin
            st_d = L_WR_HOLD;
          end
        L_WR_HOLD:
          // Full buffer stretches the clock rather than dropping a byte
          if (fifo_ready)
          begin
            push     = 1'b1;
            first_d  = 1'b0;
            sda_oe_d = 1'b1;
            scl_oe_d = 1'b0;
            st_d     = L_WR_ACK;
          end
          else
          begin
            scl_oe_d = 1'b1;
          end
        L_RD_LOAD:
          // Reply waits for setup bytes and the access outcome
          if (!pop_valid && !pend_q)
          begin
            shift_d  = resp_byte;
            sda_oe_d = !resp_byte[7];
            bit_d    = 4'h1;
            scl_oe_d = 1'b0;
            rd_clear = (idx_q == IDX_CMD);
            st_d     = L_RD;
          end
          else
          begin
            scl_oe_d = 1'b1;
          end
        L_RD:
          if (scl_fall)
          begin
            if (bit_q == BITS_BYTE)
            begin
              sda_oe_d = 1'b0;
              st_d     = L_RD_ACK;
            end
            else
            begin
              sda_oe_d = !shift_q[6];
              shift_d  = {shift_q[6:0], 1'b0};
              bit_d    = bit_q + 4'h1;
            end
          end
        L_RD_ACK:
          if (scl_rise)
          begin
            st_d = sda_sync_q[1] ? L_IDLE : L_RD_WAIT;
          end
        L_RD_WAIT:
          if (scl_fall)
          begin
            idx_d = (idx_q == POS_DONE) ? idx_q : idx_q + 3'h1;
            st_d  = L_RD_LOAD;
          end
        default: st_d = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q     <= L_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= 8'h00;
      idx_q    <= IDX_COUNT;
      first_q  <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      shift_q  <= shift_d;
      idx_q    <= idx_d;
      first_q  <= first_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
    end
  end

  // ----------------------------------------
  // Field parser and access control
  // ----------------------------------------
  assign pop_ready = !pend_q;

  always_comb
  begin
    pos_d     = pos_q;
    code_d    = code_q;
    count_d   = count_q;
    ctrl_d    = ctrl_q;
    devaddr_d = devaddr_q;
    lo_d      = lo_q;
    hi_d      = hi_q;
    rdata_d   = rdata_q;
    pend_d    = pend_q;
    req_d     = req_q;
    // Flags share the master status semantics; a set wins over the read clear
    flags_d   = rd_clear ? FLAGS_RESET : flags_q;
    if (pend_q && acc_done)
    begin
      pend_d  = 1'b0;
      flags_d = flags_d | {acc_res.misplaced, acc_res.arb_lost, acc_res.nack};
      if (req_q.rw)
      begin
        rdata_d = acc_res.rdata;
      end
    end
    if (pop_valid && pop_ready)
    begin
      if (pop_byte.first)
      begin
        code_d  = pop_byte.data;
        pos_d   = pop_byte.data[CODE_BLK_BIT] ? POS_COUNT : POS_CMD;
      end
      else
      begin
        unique case (pos_q)
          POS_COUNT:   count_d = pop_byte.data;
          POS_CMD:     ctrl_d  = pop_byte.data[1:0];
          POS_DEVADDR: devaddr_d = pop_byte.data;
          POS_ADDR_LO: lo_d = pop_byte.data;
          POS_ADDR_HI: hi_d = pop_byte.data;
          default: ;
        endcase
        pos_d = (pos_q == POS_DONE) ? pos_q : pos_q + 3'h1;
        if ((pos_q == POS_ADDR_HI && ctrl_q[CMD_RW_BIT]) || (pos_q == POS_DATA && !ctrl_q[CMD_RW_BIT]))
        begin
          pend_d         = 1'b1;
          req_d.rw       = ctrl_q[CMD_RW_BIT];
          req_d.dev_addr = ctrl_q[CMD_GIVEN_BIT] ? devaddr_q[7:1] : cfg_eeprom_addr;
          req_d.byte_addr = (pos_q == POS_ADDR_HI) ? {pop_byte.data, lo_q} : {hi_q, lo_q};
          req_d.wdata    = pop_byte.data;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pos_q     <= POS_CODE;
      code_q    <= 8'h00;
      count_q   <= 8'h00;
      ctrl_q    <= CTRL_RESET;
      flags_q   <= FLAGS_RESET;
      devaddr_q <= 8'h00;
      lo_q      <= 8'h00;
      hi_q      <= 8'h00;
      rdata_q   <= 8'h00;
      pend_q    <= 1'b0;
      req_q     <= '0;
    end
    else
    begin
      pos_q     <= pos_d;
      code_q    <= code_d;
      count_q   <= count_d;
      ctrl_q    <= ctrl_d;
      flags_q   <= flags_d;
      devaddr_q <= devaddr_d;
      lo_q      <= lo_d;
      hi_q      <= hi_d;
      rdata_q   <= rdata_d;
      pend_q    <= pend_d;
      req_q     <= req_d;
    end
  end

  // ----------------------------------------
  // Outputs, open drain pins drive low only
  // ----------------------------------------
  assign scl_out       = 1'b0;
  assign sda_out       = 1'b0;
  assign scl_oe        = scl_oe_q;
  assign sda_oe        = sda_oe_q;
  assign acc_req_valid = pend_q;
  assign acc_req       = req_q;
  assign cmd_status    = {2'h0, flags_q, 1'b0, ctrl_q};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_issue;
    !pend_q ##1 pend_q;
  endsequence

  sequence s_finish;
    pend_q && acc_done;
  endsequence

  a_rw_from_cmd: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_issue |-> acc_req.rw == $past(ctrl_q[CMD_RW_BIT])) else $error("access direction not from command bit");

  a_given_addr_used: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_issue |-> acc_req.dev_addr == ($past(ctrl_q[CMD_GIVEN_BIT]) ? $past(devaddr_q[7:1]) : $past(cfg_eeprom_addr)))
    else $error("wrong eeprom device address");

  a_nack_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pend_q && acc_done && acc_res.nack |=> cmd_status[CMD_NACK_BIT]) else $error("nack flag not set");

  a_arb_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pend_q && acc_done && acc_res.arb_lost |=> cmd_status[CMD_ARB_BIT]) else $error("arbitration flag not set");

  a_cond_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pend_q && acc_done && acc_res.misplaced |=> cmd_status[CMD_COND_BIT]) else $error("misplaced flag not set");

  a_flags_clear_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_clear && !(pend_q && acc_done) |=> cmd_status[5:3] == 3'h0) else $error("flags not cleared on read");

  a_one_access: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_finish |=> !pend_q ##1 !pend_q || $past(pop_valid)) else $error("access repeated");

  a_reply_stretch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_q == L_RD_LOAD && pend_q |=> scl_oe) else $error("reply not held while access pending");

  a_addr_pair: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_issue |-> acc_req.byte_addr == {hi_q, lo_q}) else $error("byte address halves swapped");

  a_slave_drive_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sda_oe |-> st_q inside {L_ADDR_ACK, L_WR_HOLD, L_WR_ACK, L_RD, L_RD_LOAD, L_RD_ACK})
    else $error("sda driven out of turn");
endmodule
`default_nettype wire

// File: inc/eeacc_pkg.sv
`default_nettype none
package eeacc_pkg;

  // ----------------------------------------
  // Byte positions after the slave address
  // ----------------------------------------
  localparam logic [2:0] POS_CODE    = 3'h0;
  localparam logic [2:0] POS_COUNT   = 3'h1;
  localparam logic [2:0] POS_CMD     = 3'h2;
  localparam logic [2:0] POS_DEVADDR = 3'h3;
  localparam logic [2:0] POS_ADDR_LO = 3'h4;
  localparam logic [2:0] POS_ADDR_HI = 3'h5;
  localparam logic [2:0] POS_DATA    = 3'h6;
  localparam logic [2:0] POS_DONE    = 3'h7;

  // ----------------------------------------
  // Command byte fields
  // ----------------------------------------
  localparam int         CMD_RW_BIT    = 0;
  localparam int         CMD_GIVEN_BIT = 1;
  localparam int         CMD_NACK_BIT  = 3;
  localparam int         CMD_ARB_BIT   = 4;
  localparam int         CMD_COND_BIT  = 5;
  localparam logic [1:0] CTRL_RESET    = 2'h0;
  localparam logic [2:0] FLAGS_RESET   = 3'h0;
  localparam int         CODE_BLK_BIT  = 7;

  // ----------------------------------------
  // Response and buffering
  // ----------------------------------------
  localparam logic [7:0] RESP_COUNT = 8'h05;
  localparam logic [7:0] IDLE_FILL  = 8'hff;
  localparam logic [2:0] IDX_COUNT  = 3'h0;
  localparam logic [2:0] IDX_CMD    = 3'h1;
  localparam logic [2:0] IDX_LAST   = 3'h5;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam int         FIFO_DEPTH = 8;

  typedef struct packed {
    logic        rw;
    logic [6:0]  dev_addr;
    logic [15:0] byte_addr;
    logic [7:0]  wdata;
  } acc_req_s;

  typedef struct packed {
    logic       nack;
    logic       arb_lost;
    logic       misplaced;
    logic [7:0] rdata;
  } acc_res_s;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } link_byte_s;

endpackage
`default_nettype wire

// File: src/byte_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             do_wr;
  logic             do_rd;

  // ----------------------------------------
  // Pointers, one wrap bit above the index
  // ----------------------------------------
  always_comb
  begin
    in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    out_valid = (wr_q != rd_q);
    do_wr     = in_valid && in_ready;
    do_rd     = out_valid && out_ready;
    wr_d      = do_wr ? wr_q + 1'b1 : wr_q;
    rd_d      = do_rd ? rd_q + 1'b1 : rd_q;
    out_data  = mem[rd_q[AW-1:0]];
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // No reset on storage; only written slots are ever read
  always_ff @(posedge ref_clk)
  begin
    if (do_wr)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: verification/smbus_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  // ----------------------------------------
  // Open-drain host, 160 ns link clock
  // ----------------------------------------
  int stuck_count = 0;

  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Slave may stretch, so wait for the wire, bounded
  task automatic release_scl();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl_line !== 1'b1 && n < 5000)
    begin
      #8;
      n++;
    end
    if (scl_line !== 1'b1)
    begin
      stuck_count++;
    end
  endtask

  // Released data reads as the pull-up level
  task automatic clk_bit(input logic d, output logic q);
    sda_low = !d;
    #80;
    release_scl();
    #40;
    q = sda_line;
    #40;
    scl_low = 1'b1;
  endtask

  task automatic start_cond();
    sda_low = 1'b0;
    #80;
    release_scl();
    #80;
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    #80;
    release_scl();
    #80;
    sda_low = 1'b0;
    #160;
  endtask

  // Ack slot: host releases, or drives its own ack bit
  task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(ack_bit, ack);
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import eeacc_pkg::*;
  localparam logic [6:0] OWN_ADDR = 7'h2a;
  localparam logic [6:0] CFG_ADDR = 7'h50;

  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       scl_oe, sda_oe, scl_low, sda_low, acc_req_valid, scl_drv, sda_drv;
  logic       acc_done = 1'b0;
  wire        scl_line, sda_line;
  acc_req_s   acc_req, seen_req;
  acc_res_s   acc_res = '0;
  logic [7:0] cmd_status;
  int         bad_count = 0, num_checks = 0, n_acc = 0, wait_cnt = 0, resp_wait = 2, cycles = 0;

  // Wired-AND of both parties with pull-ups
  assign scl_line = !scl_low && (scl_oe ? scl_drv : 1'b1);
  assign sda_line = !sda_low && (sda_oe ? sda_drv : 1'b1);

  smbus_eeprom_access_cmd u_smbus_eeprom_access_cmd (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .slave_addr(OWN_ADDR), .cfg_eeprom_addr(CFG_ADDR),
    .scl_in(scl_line), .scl_out(scl_drv), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_drv), .sda_oe(sda_oe),
    .acc_req_valid(acc_req_valid), .acc_req(acc_req), .acc_done(acc_done), .acc_res(acc_res),
    .cmd_status(cmd_status)
  );

  smbus_host_model u_smbus_host_model (
    .scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low)
  );

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Master engine stand-in, adjustable delay
  // ----------------------------------------
  always @(negedge ref_clk)
  begin
    if (acc_req_valid && !acc_done && wait_cnt >= resp_wait)
    begin
      acc_done <= 1'b1;
      wait_cnt <= 0;
      seen_req <= acc_req;
      n_acc    <= n_acc + 1;
    end
    else
    begin
      acc_done <= 1'b0;
      if (acc_req_valid && !acc_done)
      begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Checks and link sequences
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic send(input logic [7:0] q[$]);
    logic [7:0] r;
    logic       a;
    u_smbus_host_model.start_cond();
    u_smbus_host_model.xfer({OWN_ADDR, 1'b0}, 1'b1, r, a);
    chk("address ack", 32'h0, {31'h0, a});
    foreach (q[i])
    begin
      u_smbus_host_model.xfer(q[i], 1'b1, r, a);
      chk("byte ack", 32'h0, {31'h0, a});
    end
    u_smbus_host_model.stop_cond();
  endtask

  // Host acks all but the last reply byte
  task automatic fetch(input logic [7:0] e[$]);
    logic [7:0] r;
    logic       a;
    u_smbus_host_model.start_cond();
    u_smbus_host_model.xfer({OWN_ADDR, 1'b1}, 1'b1, r, a);
    chk("read address ack", 32'h0, {31'h0, a});
    foreach (e[i])
    begin
      u_smbus_host_model.xfer(8'hff, i == e.size() - 1, r, a);
      chk("reply byte", {24'h0, e[i]}, {24'h0, r});
    end
    u_smbus_host_model.stop_cond();
  endtask

  task automatic wait_acc(input int n);
    int k;
    k = 0;
    while ((n_acc != n || acc_req_valid !== 1'b0) && k < 3000)
    begin
      @(negedge ref_clk);
      k++;
    end
    repeat (2) @(negedge ref_clk);
    chk("access settled", 32'h0, {31'h0, acc_req_valid});
    chk("access count", n, n_acc);
  endtask

  initial
  begin
    logic [7:0] r;
    logic       a;
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("status after reset", 32'h0, {24'h0, cmd_status});
    // Foreign address must stay unacknowledged
    u_smbus_host_model.start_cond();
    u_smbus_host_model.xfer({7'h11, 1'b0}, 1'b1, r, a);
    chk("foreign ack", 32'h1, {31'h0, a});
    u_smbus_host_model.stop_cond();
    // Block write, configured device address
    send('{8'h80, 8'h05, 8'h00, 8'ha4, 8'h34, 8'h12, 8'h5a});
    wait_acc(1);
    chk("write request", {1'b0, CFG_ADDR, 16'h1234, 8'h5a}, seen_req);
    // Block read setup, given address, slow engine with a NACK
    resp_wait = 40;
    acc_res   = '{nack: 1'b1, arb_lost: 1'b0, misplaced: 1'b0, rdata: 8'hc3};
    send('{8'h80, 8'h04, 8'h03, 8'ha4, 8'h02, 8'h01});
    wait_acc(2);
    chk("read request", {8'h0, 1'b1, 7'h52, 16'h0102}, {8'h0, seen_req[31:8]});
    chk("nack flag set", 32'h0b, {24'h0, cmd_status});
    fetch('{8'h05, 8'h0b, 8'ha4, 8'h02, 8'h01, 8'hc3});
    chk("nack flag cleared", 32'h03, {24'h0, cmd_status});
    // Byte-type read setup, prompt engine, other two flags
    resp_wait = 0;
    acc_res   = '{nack: 1'b0, arb_lost: 1'b1, misplaced: 1'b1, rdata: 8'h7e};
    send('{8'h00, 8'h01, 8'ha4, 8'h10, 8'h00});
    wait_acc(3);
    chk("byte read request", {8'h0, 1'b1, CFG_ADDR, 16'h0010}, {8'h0, seen_req[31:8]});
    chk("arb and cond set", 32'h31, {24'h0, cmd_status});
    fetch('{8'h31, 8'ha4, 8'h10, 8'h00, 8'h7e});
    chk("flags cleared", 32'h01, {24'h0, cmd_status});
    // Reply asked for while the access still runs: SCL held
    resp_wait = 400;
    acc_res   = '{nack: 1'b0, arb_lost: 1'b1, misplaced: 1'b0, rdata: 8'h96};
    send('{8'h00, 8'h01, 8'ha4, 8'h78, 8'h56});
    fetch('{8'h11, 8'ha4, 8'h78, 8'h56, 8'h96});
    chk("held reply flags cleared", 32'h01, {24'h0, cmd_status});
    wait_acc(4);
    chk("held read request", {8'h0, 1'b1, CFG_ADDR, 16'h5678}, {8'h0, seen_req[31:8]});
    chk("stretch limit", 32'h0, u_smbus_host_model.stuck_count);
    wrap_up();
  end
endmodule
`default_nettype wire
